/* File: hw/lcd_segment_pkg.sv */
// shared constants, types and field layout of the segment lcd driver
// Function
// [RULE1] drive waveforms continuously while frame clock runs
// [RULE2] software blanks display while switching frame clock
// [RULE3] two-frame alternating polarity, bias and duty configured
// [RULE4] mode stopped or reset: all outputs low; stop forces only o_drive low, pin and bias selects keep their register bits
// [RULE5] software stops display before halting frame clock
// [RULE6] three modes: half/half, third/third, third/quarter
// [RULE7] half duty uses commons zero and one
// [RULE8] third duty uses commons zero to two
// [RULE9] quarter duty scans all four commons
// [RULE10] set bit gives maximum difference to common
// [RULE11] display memory at 0x64, undefined after reset
// [RULE12] control register at 0x79, resets to 0x10
// [RULE13] pin select register at 0x7A, resets zero
// [RULE14] 5 MHz main clock, select 11 gives 76 Hz
// [RULE15] memory scanned automatically in step with common
// [RULE16] bit one selects cell, zero deselects
// [RULE17] 42 segments by four bits in 21 bytes
// [RULE18] two-bit select picks one of four frame lengths
// [RULE19] phase counter wraps at duty, polarity flips per frame
// [RULE20] blank drives all segments at deselect level
package lcd_segment_pkg;

   // ------------------------------------------------------------------
   // clocking
   // ------------------------------------------------------------------
   localparam int unsigned REF_CLK_HZ       = 100_000_000;
   localparam int unsigned MAIN_CLK_HZ      = 5_000_000;
   localparam int unsigned MAIN_TICK_CYCLES = REF_CLK_HZ / MAIN_CLK_HZ;
   localparam int unsigned FRAME_HZ_SEL3    = 76;
   // log2 of main-clock periods in one common slot for select 00
   localparam int unsigned SLOT_LOG2_BASE   = 11;

   // ------------------------------------------------------------------
   // geometry and register map
   // ------------------------------------------------------------------
   localparam int unsigned NUM_COM   = 4;
   localparam int unsigned NUM_SEG   = 42;
   localparam int unsigned MEM_BYTES = 21;
   localparam int unsigned MEM_AW    = 5;

   localparam logic [7:0] ADDR_MEM_FIRST = 8'h64;
   localparam logic [7:0] ADDR_MEM_LAST  = 8'h78;
   localparam logic [7:0] ADDR_CTL       = 8'h79;
   localparam logic [7:0] ADDR_SEG_SEL   = 8'h7A;

   localparam int unsigned CTL_FP_LSB    = 0;
   localparam int unsigned CTL_MODE_LSB  = 2;
   localparam int unsigned CTL_BLANK_BIT = 4;
   localparam int unsigned CTL_BIAS_BIT  = 5;
   localparam logic [7:0]  CTL_RESET     = 8'h10;
   localparam logic [7:0]  SEG_SEL_RESET = 8'h00;
   localparam logic [7:0]  USED_MASK     = 8'h7F;

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_STOP    = 2'b00,
      MODE_HALF    = 2'b01,
      MODE_THIRD   = 2'b10,
      MODE_QUARTER = 2'b11
   } mode_t;

   // drive level codes, in thirds of the lcd supply; half bias uses 1 as midpoint
   localparam logic [1:0] LVL_GND = 2'h0;
   localparam logic [1:0] LVL_1   = 2'h1;
   localparam logic [1:0] LVL_2   = 2'h2;
   localparam logic [1:0] LVL_TOP = 2'h3;

   typedef struct packed {
      logic [NUM_COM-1:0][1:0] com;
      logic [NUM_SEG-1:0][1:0] seg;
   } lcd_drive_t;

endpackage

/* File: hw/lcd_display_mem.sv */
// display memory with a processor port and a scan read port
`timescale 1ns/100ps
module lcd_display_mem #(
   parameter int unsigned BYTES = 21,
   parameter int unsigned AW    = 5
) (
   input  wire logic          i_ref_clk,
   input  wire logic          i_reset_n,
   input  wire logic          i_cpu_rd,
   input  wire logic          i_cpu_we,
   input  wire logic          i_cpu_sel,
   input  wire logic [AW-1:0] i_cpu_addr,
   input  wire logic [7:0]    i_cpu_wdata,
   input  wire logic [7:0]    i_cpu_alt,
   output logic      [7:0]    o_cpu_rdata,
   input  wire logic [AW-1:0] i_scan_addr,
   output logic      [7:0]    o_scan_rdata
);

   logic [7:0] mem [BYTES];

   // contents are not reset
   always_ff @(posedge i_ref_clk) begin
      if (i_cpu_we && i_cpu_sel) begin
         mem[i_cpu_addr] <= i_cpu_wdata; // RULE11
      end
   end

   // read data live only in the cycle after a read
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_cpu_rdata <= 8'h00;
      end else if (i_cpu_rd) begin
         o_cpu_rdata <= i_cpu_sel ? mem[i_cpu_addr] : i_cpu_alt; // RULE11
      end else begin
         o_cpu_rdata <= 8'h00;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_scan_rdata <= 8'h00;
      end else begin
         o_scan_rdata <= mem[i_scan_addr]; // RULE15
      end
   end

endmodule

/* File: hw/lcd_segment_common_driver.sv */
// segment lcd controller: registers, frame timing, memory scan and drive levels
`timescale 1ns/100ps
module lcd_segment_common_driver #(
   parameter int unsigned SLOT_LOG2_BASE = lcd_segment_pkg::SLOT_LOG2_BASE
) (
   input  wire logic                        i_ref_clk,
   input  wire logic                        i_reset_n,
   input  wire logic [7:0]                  i_addr,
   input  wire logic [7:0]                  i_wdata,
   input  wire logic                        i_wr,
   input  wire logic                        i_rd,
   output logic      [7:0]                  o_rdata,
   input  wire logic                        i_main_clk_run,
   output lcd_segment_pkg::lcd_drive_t      o_drive,
   output logic      [6:0]                  o_seg_pin_select,
   output logic                             o_bias_divider_select
);

   // ------------------------------------------------------------------
   // local constants and helpers
   // ------------------------------------------------------------------
   localparam int unsigned TICK_W = $clog2(lcd_segment_pkg::MAIN_TICK_CYCLES);
   localparam logic [TICK_W-1:0] TICK_LAST =
      TICK_W'(lcd_segment_pkg::MAIN_TICK_CYCLES - 1);
   localparam int unsigned SLOT_W = SLOT_LOG2_BASE + 4;
   localparam logic [4:0] SCAN_LAST = 5'(lcd_segment_pkg::MEM_BYTES - 1);

   // last common index of each mode
   function automatic logic [1:0] duty_last(input lcd_segment_pkg::mode_t m);
      case (m)
         lcd_segment_pkg::MODE_HALF:    duty_last = 2'h1; // RULE7
         lcd_segment_pkg::MODE_THIRD:   duty_last = 2'h2; // RULE8
         lcd_segment_pkg::MODE_QUARTER: duty_last = 2'h3; // RULE9
         default:                       duty_last = 2'h0;
      endcase
   endfunction

   // main-clock periods per common slot minus one; select 11 in quarter
   // duty gives 2^16 periods per frame, about 76 Hz from 5 MHz
   function automatic logic [SLOT_W-1:0] slot_last(input logic [1:0] fp);
      slot_last = SLOT_W'((32'd1 << (SLOT_LOG2_BASE + 32'(fp))) - 32'd1); // RULE14 RULE18
   endfunction

   function automatic logic [1:0] seg_off_level(input logic pol, input logic half);
      seg_off_level = half ? lcd_segment_pkg::LVL_1 :
                      (pol ? lcd_segment_pkg::LVL_1 : lcd_segment_pkg::LVL_2);
   endfunction

   function automatic logic [1:0] seg_on_level(input logic pol);
      seg_on_level = pol ? lcd_segment_pkg::LVL_TOP : lcd_segment_pkg::LVL_GND;
   endfunction

   function automatic logic [1:0] com_sel_level(input logic pol);
      com_sel_level = pol ? lcd_segment_pkg::LVL_GND : lcd_segment_pkg::LVL_TOP;
   endfunction

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   logic [7:0] ctl_reg;
   logic [7:0] seg_sel_reg;

   lcd_segment_pkg::mode_t mode;
   logic [1:0]             fp_sel;
   logic                   blank;
   logic                   running;
   logic                   half_bias;

   assign mode      = lcd_segment_pkg::mode_t'(ctl_reg[lcd_segment_pkg::CTL_MODE_LSB +: 2]);
   assign fp_sel    = ctl_reg[lcd_segment_pkg::CTL_FP_LSB +: 2];
   assign blank     = ctl_reg[lcd_segment_pkg::CTL_BLANK_BIT];
   assign running   = (mode != lcd_segment_pkg::MODE_STOP);
   assign half_bias = (mode == lcd_segment_pkg::MODE_HALF); // RULE6

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctl_reg     <= lcd_segment_pkg::CTL_RESET; // RULE12
         seg_sel_reg <= lcd_segment_pkg::SEG_SEL_RESET; // RULE13
      end else if (i_wr) begin
         if (i_addr == lcd_segment_pkg::ADDR_CTL) begin
            ctl_reg <= i_wdata & lcd_segment_pkg::USED_MASK; // RULE12
         end
         if (i_addr == lcd_segment_pkg::ADDR_SEG_SEL) begin
            seg_sel_reg <= i_wdata & lcd_segment_pkg::USED_MASK; // RULE13
         end
      end
   end

   assign o_seg_pin_select      = seg_sel_reg[6:0];
   assign o_bias_divider_select = ctl_reg[lcd_segment_pkg::CTL_BIAS_BIT];

   // ------------------------------------------------------------------
   // bus decode and display memory
   // ------------------------------------------------------------------
   logic       mem_hit;
   logic [4:0] mem_index;
   logic [7:0] alt_rdata;
   logic [4:0] scan_addr_reg;
   logic [7:0] scan_byte;

   assign mem_hit   = (i_addr >= lcd_segment_pkg::ADDR_MEM_FIRST) &&
                      (i_addr <= lcd_segment_pkg::ADDR_MEM_LAST);
   assign mem_index = 5'(i_addr - lcd_segment_pkg::ADDR_MEM_FIRST);
   assign alt_rdata = (i_addr == lcd_segment_pkg::ADDR_CTL)     ? ctl_reg :
                      (i_addr == lcd_segment_pkg::ADDR_SEG_SEL) ? seg_sel_reg : 8'h00;

   lcd_display_mem #(
      .BYTES (lcd_segment_pkg::MEM_BYTES),
      .AW    (lcd_segment_pkg::MEM_AW)
   ) u_mem (
      .i_ref_clk    (i_ref_clk),
      .i_reset_n    (i_reset_n),
      .i_cpu_rd     (i_rd),
      .i_cpu_we     (i_wr),
      .i_cpu_sel    (mem_hit),
      .i_cpu_addr   (mem_index),
      .i_cpu_wdata  (i_wdata),
      .i_cpu_alt    (alt_rdata),
      .o_cpu_rdata  (o_rdata),
      .i_scan_addr  (scan_addr_reg),
      .o_scan_rdata (scan_byte)
   );

   // ------------------------------------------------------------------
   // frame timing
   // ------------------------------------------------------------------
   logic [TICK_W-1:0] tick_cnt_reg;
   logic [SLOT_W-1:0] slot_cnt_reg;
   logic [1:0]        com_idx_reg;
   logic              polarity_reg;
   logic              main_tick;
   logic              slot_end;

   // a stopped main clock freezes tick, slot, common and polarity; the memory scan keeps running
   assign main_tick = running && i_main_clk_run && (tick_cnt_reg == TICK_LAST); // RULE1
   assign slot_end  = main_tick && (slot_cnt_reg >= slot_last(fp_sel));

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tick_cnt_reg <= '0;
      end else if (!running) begin
         tick_cnt_reg <= '0;
      end else if (i_main_clk_run) begin
         tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? '0 : tick_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         slot_cnt_reg <= '0;
      end else if (!running) begin
         slot_cnt_reg <= '0;
      end else if (main_tick) begin
         slot_cnt_reg <= slot_end ? '0 : slot_cnt_reg + 1'b1; // RULE18
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         com_idx_reg  <= 2'h0;
         polarity_reg <= 1'b0;
      end else if (!running) begin
         com_idx_reg  <= 2'h0;
         polarity_reg <= 1'b0;
      end else if (slot_end) begin
         if (com_idx_reg >= duty_last(mode)) begin
            com_idx_reg  <= 2'h0; // RULE19
            polarity_reg <= ~polarity_reg; // RULE3
         end else begin
            com_idx_reg <= com_idx_reg + 2'h1; // RULE19
         end
      end
   end

   // ------------------------------------------------------------------
   // memory scan: one pass of 21 reads per update of the segment image
   // ------------------------------------------------------------------
   logic [1:0]                              scan_com_reg;
   logic                                    scan_pol_reg;
   logic                                    scan_valid_reg;
   logic [4:0]                              scan_addr_q_reg;
   logic [lcd_segment_pkg::NUM_SEG-1:0]     shadow_reg;
   logic [lcd_segment_pkg::NUM_SEG-1:0]     shadow_next;
   logic [lcd_segment_pkg::NUM_SEG-1:0]     disp_seg_reg;
   logic [1:0]                              disp_com_reg;
   logic                                    disp_pol_reg;
   logic                                    disp_valid_reg;

   always_comb begin
      shadow_next = shadow_reg;
      if (scan_valid_reg) begin
         shadow_next[{scan_addr_q_reg, 1'b0}] = scan_byte[{1'b0, scan_com_reg}]; // RULE17
         shadow_next[{scan_addr_q_reg, 1'b1}] = scan_byte[{1'b1, scan_com_reg}]; // RULE17
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         scan_addr_reg   <= 5'h00;
         scan_addr_q_reg <= 5'h00;
         scan_valid_reg  <= 1'b0;
         scan_com_reg    <= 2'h0;
         scan_pol_reg    <= 1'b0;
      end else if (!running) begin
         scan_addr_reg   <= 5'h00;
         scan_addr_q_reg <= 5'h00;
         scan_valid_reg  <= 1'b0;
         scan_com_reg    <= 2'h0;
         scan_pol_reg    <= 1'b0;
      end else begin
         // a new common phase restarts the pass so the image follows it at a fixed lag
         scan_addr_reg   <= (slot_end || scan_addr_reg == SCAN_LAST) ? 5'h00 :
                            scan_addr_reg + 5'h01; // RULE15
         scan_addr_q_reg <= scan_addr_reg;
         scan_valid_reg  <= 1'b1;
         if (scan_addr_reg == 5'h00) begin
            scan_com_reg <= com_idx_reg; // RULE15
            scan_pol_reg <= polarity_reg;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         shadow_reg     <= '0;
         disp_seg_reg   <= '0;
         disp_com_reg   <= 2'h0;
         disp_pol_reg   <= 1'b0;
         disp_valid_reg <= 1'b0;
      end else if (!running) begin
         disp_valid_reg <= 1'b0;
      end else begin
         shadow_reg <= shadow_next;
         if (scan_valid_reg && (scan_addr_q_reg == SCAN_LAST)) begin
            disp_seg_reg   <= shadow_next;
            disp_com_reg   <= scan_com_reg;
            disp_pol_reg   <= scan_pol_reg;
            disp_valid_reg <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // drive levels
   // ------------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_drive <= '0; // RULE4
      end else if (!running || !disp_valid_reg) begin
         o_drive <= '0; // RULE4
      end else begin
         for (int c = 0; c < lcd_segment_pkg::NUM_COM; c++) begin
            if (2'(c) > duty_last(mode)) begin
               o_drive.com[c] <= lcd_segment_pkg::LVL_GND; // RULE7 RULE8
            end else if (2'(c) == disp_com_reg) begin
               o_drive.com[c] <= com_sel_level(disp_pol_reg); // RULE3 RULE9
            end else begin
               o_drive.com[c] <= seg_off_level(~disp_pol_reg, half_bias); // RULE3
            end
         end
         for (int s = 0; s < lcd_segment_pkg::NUM_SEG; s++) begin
            if (blank || !disp_seg_reg[s]) begin
               o_drive.seg[s] <= seg_off_level(disp_pol_reg, half_bias); // RULE16 RULE20
            end else begin
               o_drive.seg[s] <= seg_on_level(disp_pol_reg); // RULE10 RULE16
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   chk_stop_outputs_low: assert property ( // RULE4
      !running |=> (o_drive == '0))
      else $error("outputs not low while stopped");

   chk_half_com_unused: assert property ( // RULE7
      (mode == lcd_segment_pkg::MODE_HALF) |=>
      (o_drive.com[2] == 2'h0 && o_drive.com[3] == 2'h0))
      else $error("half duty drives common two or three");

   chk_third_com_unused: assert property ( // RULE8
      (mode == lcd_segment_pkg::MODE_THIRD) |=> (o_drive.com[3] == 2'h0))
      else $error("third duty drives common three");

   chk_com_index_wrap: assert property ( // RULE19
      (running && slot_end && com_idx_reg >= duty_last(mode)) |=>
      (com_idx_reg == 2'h0 && polarity_reg != $past(polarity_reg)))
      else $error("common phase did not wrap with polarity flip");

   chk_quarter_step: assert property ( // RULE9
      (mode == lcd_segment_pkg::MODE_QUARTER && slot_end && com_idx_reg != 2'h3 &&
       $stable(mode)) |=> (com_idx_reg == $past(com_idx_reg) + 2'h1))
      else $error("quarter duty common did not step");

   chk_slot_bounded: assert property ( // RULE18
      (running && $stable(fp_sel)) |-> (slot_cnt_reg <= slot_last(fp_sel)))
      else $error("slot counter beyond selected length");

   chk_blank_deselect: assert property ( // RULE20
      (running && blank && disp_valid_reg) |=>
      (o_drive.seg[0] == seg_off_level($past(disp_pol_reg), $past(half_bias)) &&
       o_drive.seg[41] == seg_off_level($past(disp_pol_reg), $past(half_bias))))
      else $error("segment not deselected while blank");

   chk_on_max_diff: assert property ( // RULE10
      (running && !blank && disp_valid_reg && disp_seg_reg[0] && $stable(disp_pol_reg) &&
       $stable(disp_com_reg) && disp_com_reg <= duty_last(mode)) |=>
      ((o_drive.seg[0] ^ o_drive.com[$past(disp_com_reg)]) == 2'h3))
      else $error("on segment not at maximum difference");

   chk_scan_pass_len: assert property ( // RULE15
      disable iff (!i_reset_n || !running || slot_end)
      (running && scan_addr_reg == 5'h00) |-> ##21 (!running || scan_addr_reg == 5'h00))
      else $error("scan pass not 21 reads");

   chk_scan_restart: assert property ( // RULE15
      slot_end |=> (scan_addr_reg == 5'h00))
      else $error("scan pass not restarted at common change");

   chk_blank_com_driven: assert property ( // RULE1
      (running && blank && disp_valid_reg) |=> ((o_drive.com[0] | o_drive.com[1]) != 2'h0))
      else $error("commons not driven while blank");

   chk_read_one_cycle: assert property ( // RULE12
      (!i_rd) |=> (o_rdata == 8'h00))
      else $error("read data outside read answer cycle");

   cov_quarter_flip: cover property (
      mode == lcd_segment_pkg::MODE_QUARTER && slot_end && com_idx_reg == 2'h3);
   cov_half_running: cover property (
      mode == lcd_segment_pkg::MODE_HALF && disp_valid_reg);
   cov_blank_on: cover property (running && blank && disp_valid_reg);
   cov_clock_frozen: cover property (running && !i_main_clk_run ##1 i_main_clk_run);
   cov_scan_restart: cover property (slot_end && scan_addr_reg != 5'h00);

endmodule

/* File: bench/lcd_panel_model.sv */
// panel model: scanned common, frame polarity and fully driven cells
`timescale 1ns/100ps
module lcd_panel_model (
   input  wire lcd_segment_pkg::lcd_drive_t i_drive,
   input  wire logic [3:0]                  i_com_used,
   output logic      [1:0]                  o_sel,
   output logic                             o_sel_valid,
   output logic                             o_pol,
   output logic      [41:0]                 o_on
);
   logic [1:0] lvl;
   always_comb begin
      o_sel = 2'h0;
      o_sel_valid = 1'b0;
      o_pol = 1'b0;
      for (int c = 0; c < 4; c++) begin
         lvl = i_drive.com[c];
         if (i_com_used[c] && (lvl == 2'h3 || lvl == 2'h0)) begin
            o_sel = c[1:0];
            o_sel_valid = 1'b1;
            o_pol = (lvl == 2'h0);
         end
      end
      lvl = i_drive.com[o_sel];
      for (int s = 0; s < 42; s++) begin
         o_on[s] = (lvl == 2'h3 && i_drive.seg[s] == 2'h0) ||
                   (lvl == 2'h0 && i_drive.seg[s] == 2'h3);
      end
   end
endmodule

/* File: bench/lcd_segment_common_driver_bench.sv */
// self-checking bench for the segment lcd driver
`timescale 1ns/100ps
module lcd_segment_common_driver_bench;
   localparam int unsigned SLOT_BASE = 1;
   logic                        i_ref_clk = 1'b0;
   logic                        i_reset_n = 1'b0;
   logic [7:0]                  addr = 8'h00;
   logic [7:0]                  wdata = 8'h00;
   logic                        wr = 1'b0;
   logic                        rd = 1'b0;
   logic                        clk_run = 1'b1;
   logic [7:0]                  rdata;
   lcd_segment_pkg::lcd_drive_t drive;
   logic [6:0]                  pin_sel;
   logic                        bias_sel;
   logic [3:0]                  com_used = 4'h0;
   logic [1:0]                  sel;
   logic                        sel_valid;
   logic                        pol;
   logic [41:0]                 on;
   int                          failures = 0;
   int                          checks_done = 0;

   initial begin
      forever #5 i_ref_clk = ~i_ref_clk;
   end

   lcd_segment_common_driver #(.SLOT_LOG2_BASE(SLOT_BASE)) lcd_segment_common_driver_i (
      .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_main_clk_run(clk_run),
      .o_drive(drive), .o_seg_pin_select(pin_sel), .o_bias_divider_select(bias_sel));

   lcd_panel_model lcd_panel_model_i (
      .i_drive(drive), .i_com_used(com_used), .o_sel(sel), .o_sel_valid(sel_valid),
      .o_pol(pol), .o_on(on));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge i_ref_clk);
      wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_ref_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge i_ref_clk);
      rd <= 1'b0;
      @(negedge i_ref_clk);
      d = rdata;
   endtask

   task automatic rd_check(input string name, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      bus_rd(a, d);
      check(name, d, exp);
   endtask

   // runs one mode and watches the panel for two frames and two more common slots
   task automatic run_mode(input logic [1:0] mode, input logic [1:0] fp, input logic blank);
      int slot;
      int duty;
      int len;
      int started;
      int bad_unused;
      int bad_cell;
      int bad_pol;
      int bad_slot;
      logic [3:0] seen;
      logic [1:0] seen_pol;
      logic [1:0] prev_sel;
      logic       prev_pol;
      slot = lcd_segment_pkg::MAIN_TICK_CYCLES << (SLOT_BASE + fp);
      duty = (mode == 2'b01) ? 2 : (mode == 2'b10) ? 3 : 4;
      {len, started, bad_unused, bad_cell, bad_pol, bad_slot} = '0;
      seen = 4'h0;
      seen_pol = 2'b00;
      com_used = 4'((1 << duty) - 1);
      bus_wr(lcd_segment_pkg::ADDR_CTL, 8'h10);
      bus_wr(lcd_segment_pkg::ADDR_CTL, {3'b001, blank, mode, fp});
      repeat (60) @(negedge i_ref_clk);
      prev_sel = sel;
      prev_pol = pol;
      for (int n = 0; n < slot * (2 * duty + 2); n++) begin
         @(negedge i_ref_clk);
         len++;
         for (int c = 0; c < 4; c++) begin
            if (!com_used[c] && drive.com[c] !== 2'h0) bad_unused++;
         end
         if (sel_valid !== 1'b1) bad_cell++;
         else if (sel !== prev_sel) begin
            if (started == 1 && len != slot) bad_slot++;
            if ((sel == 2'h0) == (pol == prev_pol)) bad_pol++;
            started = 1;
            len = 0;
         end
         seen[sel] = 1'b1;
         seen_pol[pol] = 1'b1;
         if (len >= 30 && blank && on !== 42'h0) bad_cell++;
         if (len >= 30 && !blank && on[1:0] !== {sel[0], ~sel[0]}) bad_cell++;
         prev_sel = sel;
         prev_pol = pol;
      end
      check("unused_com", bad_unused, 0);
      check("com_scan", seen, com_used);
      check("polarity_seen", seen_pol, 2'b11);
      check("polarity_flip", bad_pol, 0);
      check("slot_length", bad_slot, 0);
      check("cells", bad_cell, 0);
   endtask

   task automatic end_of_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge i_ref_clk);
      i_reset_n <= 1'b1;
      @(negedge i_ref_clk);
      check("drive_reset", drive === '0, 1'b1);
      rd_check("ctl_reset", 8'h79, lcd_segment_pkg::CTL_RESET);
      rd_check("pinsel_reset", 8'h7A, 8'h00);
      rd_check("unmapped_7b", 8'h7B, 8'h00);
      rd_check("unmapped_63", 8'h63, 8'h00);
      @(negedge i_ref_clk);
      check("rdata_idle", rdata, 8'h00);
      bus_wr(8'h64, 8'hA5);
      bus_wr(8'h78, 8'h3C);
      rd_check("mem_first", 8'h64, 8'hA5);
      rd_check("mem_last", 8'h78, 8'h3C);
      bus_wr(8'h7A, 8'hFF);
      rd_check("pinsel_rw", 8'h7A, 8'h7F);
      check("pinsel_out", pin_sel, 7'h7F);
      bus_wr(8'h79, 8'hFF);
      rd_check("ctl_rw", 8'h79, 8'h7F);
      @(negedge i_ref_clk);
      check("bias_out", bias_sel, 1'b1);
      run_mode(2'b01, 2'h0, 1'b0);
      run_mode(2'b10, 2'h1, 1'b0);
      run_mode(2'b11, 2'h2, 1'b0);
      @(posedge i_ref_clk);
      i_reset_n <= 1'b0;
      repeat (3) @(negedge i_ref_clk);
      check("drive_in_reset", drive === '0, 1'b1);
      @(posedge i_ref_clk);
      i_reset_n <= 1'b1;
      rd_check("ctl_rereset", 8'h79, 8'h10);
      run_mode(2'b11, 2'h0, 1'b1);
      rd_check("mem_kept", 8'h64, 8'hA5);
      bus_wr(8'h79, 8'h00);
      repeat (2) @(negedge i_ref_clk);
      check("drive_stop", drive === '0, 1'b1);
      clk_run <= 1'b0;
      end_of_test();
   end
endmodule
